// ### logic/adc_conv_ctrl.sv
// Converter control and status registers behind an AXI4-Lite slave
//
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/100ps
module adc_conv_ctrl
  import adc_ctrl_pkg::*;
(
  input wire logic clk, // Bus clock
  input wire logic rst, // Synchronous reset, active high
  input wire logic [31:0] s_axi_awaddr, // Write address
  input wire logic [2:0] s_axi_awprot, // Write protection, unused
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write byte strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [31:0] s_axi_araddr, // Read address
  input wire logic [2:0] s_axi_arprot, // Read protection, unused
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  input wire logic hw_trig, // Hardware trigger pulse from a peripheral
  input wire logic hw_trig_sel, // Control register picked by the trigger
  input wire conv_stat_s stat, // Converter core answers
  output conv_ctrl_s conv, // Converter core requests
  output logic irq // Level interrupt
);

  // Byte-lane merge of a bus write into a stored word
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return res;
  endfunction

  logic aw_full_ff, w_full_ff, awready_ff, wready_ff, bvalid_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic [31:0] waddr_ff, wdata_ff, rdata_ff;
  logic [3:0] wstrb_ff;
  logic arready_ff, rvalid_ff;
  logic [31:0] ctrl_ff [NCTRL];
  logic [NCTRL-1:0] coco_ff, int_status_ff, int_mask_ff;
  logic [31:0] gen_ff [NGEN];
  logic [15:0] result_ff [NCTRL];
  state_e state_ff, nxt_state;
  logic act_ff, nxt_act;
  logic [5:0] cnt_ff, nxt_cnt;
  logic [20:0] acc_ff, nxt_acc;
  conv_ctrl_s conv_ff, nxt_conv;
  logic irq_ff;

  // Write channel handshake: address and data taken in either order
  wire aw_take = s_axi_awvalid & awready_ff;
  wire w_take = s_axi_wvalid & wready_ff;
  wire wr_fire = aw_full_ff & w_full_ff & ~bvalid_ff;
  wire nxt_aw_full = (aw_full_ff | aw_take) & ~wr_fire;
  wire nxt_w_full = (w_full_ff | w_take) & ~wr_fire;
  wire rd_take = s_axi_arvalid & arready_ff;

  // Write decode
  wire [NCTRL-1:0] ctrl_wr;
  wire [NGEN-1:0] gen_wr;
  wire [NCTRL-1:0] res_rd;
  wire ist_wr = wr_fire & (waddr_ff[31:2] == OFF_INT_STATUS[31:2]);
  wire imk_wr = wr_fire & (waddr_ff[31:2] == OFF_INT_MASK[31:2]);
  wire ist_rhit = s_axi_araddr[31:2] == OFF_INT_STATUS[31:2];
  wire imk_rhit = s_axi_araddr[31:2] == OFF_INT_MASK[31:2];
  wire [31:0] wr_merged_ctrl [NCTRL];
  wire [31:0] wr_merged_gen [NGEN];

  // Read mux chains and hit chains
  wire [31:0] rd_chain [NCTRL+NGEN+1];
  wire [NCTRL+NGEN:0] rhit_chain;
  wire [NCTRL+NGEN:0] whit_chain;
  wire [31:0] rd_data = rd_chain[NCTRL+NGEN]
                        | (ist_rhit ? 32'(int_status_ff) : 32'h00000000)
                        | (imk_rhit ? 32'(int_mask_ff) : 32'h00000000);
  wire rd_hit = rhit_chain[NCTRL+NGEN] | ist_rhit | imk_rhit;
  wire wr_hit = whit_chain[NCTRL+NGEN] | ist_wr | imk_wr;
  assign rd_chain[0] = 32'h00000000;
  assign rhit_chain[0] = 1'b0;
  assign whit_chain[0] = 1'b0;

  // Mode bits steering the conversion sequencer
  wire trg_mode = gen_ff[IDX_SC2][TRG_BIT];
  wire compare_function_enable = gen_ff[IDX_SC2][COMPARE_FUNCTION_ENABLE_BIT];
  wire adco = gen_ff[IDX_SC3][ADCO_BIT];
  wire hw_average_enable = gen_ff[IDX_SC3][HW_AVERAGE_ENABLE_BIT];
  wire [1:0] average_count_select = gen_ff[IDX_SC3][1:0];
  wire [5:0] avg_last = 6'((AVG_BASE << average_count_select) - 6'h01);
  wire [2:0] avg_shift = hw_average_enable ? 3'(average_count_select) + 3'h2 : 3'h0;
  wire [4:0] ch_a = ctrl_ff[0][CH_W-1:0];
  wire [4:0] ch_act = ctrl_ff[act_ff][CH_W-1:0];
  wire [4:0] ch_trg = ctrl_ff[hw_trig_sel][CH_W-1:0];
  wire [4:0] sw_ch = wr_merged_ctrl[0][CH_W-1:0];
  wire sw_start = ctrl_wr[0] & ~trg_mode & (sw_ch != CH_OFF);
  wire hw_start = hw_trig & trg_mode & (state_ff == ST_IDLE)
                  & (ch_trg != CH_OFF);
  wire cal_req = gen_wr[IDX_SC3] & wr_merged_gen[IDX_SC3][CAL_BIT];
  wire [20:0] sum = acc_ff + 21'(stat.data);
  wire [15:0] avg_res = 16'(sum >> avg_shift);

  logic fin, cal_fin, sw_go;
  logic [1:0] restart_ff, nxt_restart;
  logic [NCTRL-1:0] coco_set;

  // Control registers with their complete flags
  genvar gi;
  generate
    for (gi = 0; gi < NCTRL; gi++) begin : g_ctrl
      wire rhit = s_axi_araddr[31:2] == CTRL_OFF[gi][31:2];
      wire rrhit = s_axi_araddr[31:2] == RES_OFF[gi][31:2];
      wire whit = waddr_ff[31:2] == CTRL_OFF[gi][31:2];
      wire wrhit = waddr_ff[31:2] == RES_OFF[gi][31:2];
      wire [31:0] rval = {24'h000000, coco_ff[gi], ctrl_ff[gi][6:0]};
      wire complete_irq_enable = ctrl_ff[gi][COMPLETE_IRQ_ENABLE_BIT];
      assign ctrl_wr[gi] = wr_fire & whit;
      assign res_rd[gi] = rd_take & rrhit;
      assign wr_merged_ctrl[gi] =
        merge(ctrl_ff[gi], wdata_ff, wstrb_ff) & CTRL_WMASK;
      assign coco_set[gi] = (fin & (act_ff == 1'(gi))
                             & (~compare_function_enable | stat.compare_true))
                            | (cal_fin & (gi == 0));
      assign rd_chain[gi+1] = rd_chain[gi]
                              | (rhit ? rval : 32'h00000000)
                              | (rrhit ? 32'(result_ff[gi]) : 32'h00000000);
      assign rhit_chain[gi+1] = rhit_chain[gi] | rhit | rrhit;
      assign whit_chain[gi+1] = whit_chain[gi] | whit | wrhit;

      // Stored fields, flag with set winning over clear, interrupt bit
      always_ff @(posedge clk) begin
        if (rst) begin
          ctrl_ff[gi] <= CTRL_RST;
          coco_ff[gi] <= 1'b0;
          int_status_ff[gi] <= 1'b0;
        end else begin
          if (ctrl_wr[gi]) begin
            ctrl_ff[gi] <= wr_merged_ctrl[gi];
          end
          coco_ff[gi] <= coco_set[gi]
                         | (coco_ff[gi] & ~ctrl_wr[gi] & ~res_rd[gi]);
          int_status_ff[gi] <= (coco_set[gi] & complete_irq_enable)
                               | (int_status_ff[gi]
                                  & ~(ist_wr & wdata_ff[gi]));
        end
      end
    end

    // Plain read/write registers
    for (gi = 0; gi < NGEN; gi++) begin : g_gen
      wire rhit = s_axi_araddr[31:2] == GEN_OFF[gi][31:2];
      wire whit = waddr_ff[31:2] == GEN_OFF[gi][31:2];
      assign gen_wr[gi] = wr_fire & whit;
      assign wr_merged_gen[gi] = merge(gen_ff[gi], wdata_ff, wstrb_ff);
      assign rd_chain[NCTRL+gi+1] = rd_chain[NCTRL+gi]
                                    | (rhit ? gen_ff[gi] : 32'h00000000);
      assign rhit_chain[NCTRL+gi+1] = rhit_chain[NCTRL+gi] | rhit;
      assign whit_chain[NCTRL+gi+1] = whit_chain[NCTRL+gi] | whit;

      // Calibration bit drops when the calibration sequence ends
      always_ff @(posedge clk) begin
        if (rst) begin
          gen_ff[gi] <= GEN_RST[gi];
        end else if (gen_wr[gi]) begin
          gen_ff[gi] <= wr_merged_gen[gi];
        end else if (gi == IDX_SC3 && cal_fin) begin
          gen_ff[gi][CAL_BIT] <= 1'b0;
        end
      end
    end
  endgenerate

  // Conversion sequencer: one governing register, aborts, averaging
  always_comb begin
    nxt_state = state_ff;
    nxt_act = act_ff;
    nxt_cnt = cnt_ff;
    nxt_acc = acc_ff;
    fin = 1'b0;
    cal_fin = 1'b0;
    sw_go = 1'b0;
    nxt_restart = {restart_ff[0], 1'b0};
    nxt_conv = '0;
    if (cal_req) begin
      nxt_conv.abort = state_ff == ST_CONV;
      nxt_conv.cal_start = 1'b1;
      nxt_state = ST_CAL;
    end else if (state_ff == ST_CAL) begin
      if (stat.cal_done) begin
        cal_fin = 1'b1;
        nxt_state = ST_IDLE;
      end
    end else begin
      if (state_ff == ST_CONV && ctrl_wr[act_ff]) begin
        nxt_conv.abort = 1'b1;
        nxt_state = ST_IDLE;
      end
      if (sw_start && nxt_conv.abort) begin
        nxt_restart = 2'b01;
      end else if (sw_start || (restart_ff[1] && ch_a != CH_OFF)) begin
        sw_go = sw_start;
        nxt_conv.start = 1'b1;
        nxt_act = 1'b0;
        nxt_state = ST_CONV;
        nxt_cnt = 6'h00;
        nxt_acc = 21'h000000;
      end else if (hw_start) begin
        nxt_conv.start = 1'b1;
        nxt_act = hw_trig_sel;
        nxt_state = ST_CONV;
        nxt_cnt = 6'h00;
        nxt_acc = 21'h000000;
      end else if (state_ff == ST_CONV && !nxt_conv.abort && stat.done) begin
        if (hw_average_enable && cnt_ff != avg_last) begin
          nxt_cnt = cnt_ff + 6'h01;
          nxt_acc = sum;
          nxt_conv.start = 1'b1;
        end else begin
          fin = 1'b1;
          nxt_cnt = 6'h00;
          nxt_acc = 21'h000000;
          if (adco && ch_act != CH_OFF) begin
            nxt_conv.start = 1'b1;
          end else begin
            nxt_state = ST_IDLE;
          end
        end
      end
    end
    nxt_conv.channel = sw_go ? sw_ch : ctrl_ff[nxt_act][CH_W-1:0];
    nxt_conv.powerdown = (nxt_state == ST_IDLE)
                         | (nxt_conv.channel == CH_OFF);
  end

  // Sequencer state and result capture
  always_ff @(posedge clk) begin
    if (rst) begin
      state_ff <= ST_IDLE;
      restart_ff <= 2'b00;
      act_ff <= 1'b0;
      cnt_ff <= 6'h00;
      acc_ff <= 21'h000000;
      conv_ff <= '{powerdown: 1'b1, channel: CH_OFF, default: 1'b0};
      result_ff <= '{default: 16'h0000};
    end else begin
      state_ff <= nxt_state;
      restart_ff <= nxt_restart;
      act_ff <= nxt_act;
      cnt_ff <= nxt_cnt;
      acc_ff <= nxt_acc;
      conv_ff <= nxt_conv;
      if (fin && (~compare_function_enable | stat.compare_true)) begin
        result_ff[act_ff] <= avg_res;
      end
    end
  end

  // Interrupt mask and level output
  always_ff @(posedge clk) begin
    if (rst) begin
      int_mask_ff <= '0;
      irq_ff <= 1'b0;
    end else begin
      if (imk_wr) begin
        int_mask_ff <= wdata_ff[NCTRL-1:0];
      end
      irq_ff <= |(int_status_ff & int_mask_ff);
    end
  end

  // AXI4-Lite write channels
  always_ff @(posedge clk) begin
    if (rst) begin
      aw_full_ff <= 1'b0;
      w_full_ff <= 1'b0;
      awready_ff <= 1'b0;
      wready_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
      waddr_ff <= 32'h00000000;
      wdata_ff <= 32'h00000000;
      wstrb_ff <= 4'h0;
    end else begin
      aw_full_ff <= nxt_aw_full;
      w_full_ff <= nxt_w_full;
      awready_ff <= ~nxt_aw_full;
      wready_ff <= ~nxt_w_full;
      if (aw_take) begin
        waddr_ff <= s_axi_awaddr;
      end
      if (w_take) begin
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      if (wr_fire) begin
        bvalid_ff <= 1'b1;
        bresp_ff <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // AXI4-Lite read channels
  always_ff @(posedge clk) begin
    if (rst) begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
      rresp_ff <= RESP_OKAY;
    end else if (rd_take) begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b1;
      rdata_ff <= rd_hit ? rd_data : 32'h00000000;
      rresp_ff <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_ff) begin
      if (s_axi_rready) begin
        rvalid_ff <= 1'b0;
        arready_ff <= 1'b1;
      end
    end else begin
      arready_ff <= 1'b1;
    end
  end

  // Outputs straight from flip-flops
  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  assign conv = conv_ff;
  assign irq = irq_ff;

endmodule

// ### logic/adc_ctrl_pkg.sv
// Constants, register map and carrier types of the converter control block
package adc_ctrl_pkg;
  // Bus and register map (byte addresses)
  localparam int DATA_W = 32;
  localparam int NCTRL = 2;
  localparam int NGEN = 15;
  localparam logic [31:0] OFF_CTRL_A = 32'h4003b000;
  localparam logic [31:0] OFF_CTRL_B = 32'h4003b004;
  localparam logic [31:0] OFF_RESULT_A = 32'h4003b010;
  localparam logic [31:0] OFF_RESULT_B = 32'h4003b014;
  localparam logic [31:0] OFF_INT_STATUS = 32'h4003b050;
  localparam logic [31:0] OFF_INT_MASK = 32'h4003b054;
  localparam logic [31:0] CTRL_OFF [NCTRL] = '{OFF_CTRL_A, OFF_CTRL_B};
  localparam logic [31:0] RES_OFF [NCTRL] = '{OFF_RESULT_A, OFF_RESULT_B};
  // Plain read/write registers: config, compare, status_control, calibration
  localparam logic [31:0] GEN_OFF [NGEN] = '{
    32'h4003b008, 32'h4003b00c, 32'h4003b018, 32'h4003b01c,
    32'h4003b020, 32'h4003b024, 32'h4003b028, 32'h4003b02c,
    32'h4003b034, 32'h4003b038, 32'h4003b03c, 32'h4003b040,
    32'h4003b044, 32'h4003b048, 32'h4003b04c};
  localparam logic [31:0] GEN_RST [NGEN] = '{
    32'h00000000, 32'h00000000, 32'h00000000, 32'h00000000,
    32'h00000000, 32'h00000000, 32'h00000004, 32'h00008200,
    32'h0000000a, 32'h00000020, 32'h00000200, 32'h00000100,
    32'h00000080, 32'h00000040, 32'h00000020};
  localparam int IDX_SC2 = 4;
  localparam int IDX_SC3 = 5;
  // Conversion control register layout
  localparam logic [31:0] CTRL_RST = 32'h0000001f;
  localparam logic [31:0] CTRL_WMASK = 32'h0000005f;
  localparam int COCO_BIT = 7;
  localparam int COMPLETE_IRQ_ENABLE_BIT = 6;
  localparam int CH_W = 5;
  localparam logic [4:0] CH_OFF = 5'h1f;
  localparam int NUM_INPUTS = 24;
  // Status/control two and three fields
  localparam int TRG_BIT = 6;
  localparam int COMPARE_FUNCTION_ENABLE_BIT = 5;
  localparam int CAL_BIT = 7;
  localparam int ADCO_BIT = 3;
  localparam int HW_AVERAGE_ENABLE_BIT = 2;
  localparam logic [5:0] AVG_BASE = 6'h04;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {ST_IDLE, ST_CONV, ST_CAL} state_e;

  // Requests to the analog converter core
  typedef struct packed {
    logic start;
    logic abort;
    logic cal_start;
    logic powerdown;
    logic [CH_W-1:0] channel;
  } conv_ctrl_s;

  // Answers from the analog converter core
  typedef struct packed {
    logic done;
    logic cal_done;
    logic compare_true;
    logic [15:0] data;
  } conv_stat_s;
endpackage

// ### sim/adc_conv_ctrl_assertions.sv
// Concurrent checks on the converter control block ports
`timescale 1ns/100ps
module adc_conv_ctrl_chk
  import adc_ctrl_pkg::*;
(
  input wire logic clk, // Bus clock
  input wire logic rst, // Synchronous reset
  input wire logic s_axi_arvalid, // Read address valid
  input wire logic s_axi_arready, // Read address ready
  input wire logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input conv_ctrl_s conv // Converter requests
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);
  // Core requests against channel and power state
  AST_START_CH: assert property (conv.start |-> conv.channel != CH_OFF)
    else $error("start with channel switched off");
  AST_START_PWR: assert property (conv.start |-> !conv.powerdown)
    else $error("start while powered down");
  AST_OFF_PWR: assert property (
    conv.channel == CH_OFF |-> conv.powerdown)
    else $error("channel off but core powered");
  AST_ONE_START: assert property (conv.start |=> !conv.start)
    else $error("start longer than one cycle");
  AST_ABORT: assert property (conv.abort |-> !conv.start)
    else $error("abort and start together");
  AST_ABORT_IDLE: assert property (conv.abort |=> conv.powerdown)
    else $error("core left powered after abort");
  // Bus answers
  AST_R_ANS: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  AST_B_GAP: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
endmodule

// ### sim/conv_core_model.sv
// Behavioural model of the analog converter core behind the block
`timescale 1ns/100ps
module conv_core_model
  import adc_ctrl_pkg::*;
(
  input wire logic clk, // Bus clock
  input wire logic rst, // Synchronous reset
  input conv_ctrl_s conv, // Requests from the block
  input wire logic cmp, // Compare outcome to report
  input wire logic [7:0] lat, // Cycles per conversion
  output conv_stat_s stat // Answers to the block
);
  logic [7:0] cnt_ff;
  logic busy_ff;
  logic cal_ff;
  logic [4:0] ch_ff;
  logic [15:0] pat_ff;
  logic fin;
  // Answers; data keeps changing and compare is inverted outside done and cal_done
  assign fin = (busy_ff || cal_ff) && cnt_ff == 8'h0;
  assign stat = '{done: fin && busy_ff, cal_done: fin && cal_ff,
                  compare_true: fin ? cmp : ~cmp,
                  data: (fin && busy_ff) ? {ch_ff, 11'h2a5} : pat_ff};
  // Conversion timer; repeats while kept powered, abort drops the job
  always_ff @(posedge clk) begin
    pat_ff <= rst ? 16'h0 : pat_ff + 16'h3a7;
    if (rst || conv.abort) begin
      busy_ff <= 1'b0;
      cal_ff <= 1'b0;
    end else if (conv.start) begin
      busy_ff <= 1'b1;
      ch_ff <= conv.channel;
      cnt_ff <= lat;
    end else if (conv.cal_start) begin
      cal_ff <= 1'b1;
      cnt_ff <= lat;
    end else if (fin) begin
      cal_ff <= 1'b0;
      cnt_ff <= lat;
    end else if (busy_ff && conv.powerdown) begin
      busy_ff <= 1'b0;
    end else if (busy_ff || cal_ff) begin
      cnt_ff <= cnt_ff - 8'h1;
    end
  end
endmodule

// ### sim/tb_top.sv
// Self-checking bench for the converter control block
`timescale 1ns/100ps
module tb_top
  import adc_ctrl_pkg::*;
;
  logic clk, rst, hw_trig, hw_trig_sel, cmp, irq;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rd, d;
  logic [2:0] s_axi_awprot, s_axi_arprot;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic [7:0] lat;
  logic [4:0] ch;
  conv_stat_s stat;
  conv_ctrl_s conv;
  int failures, n_compared, n_start, n_abort, n_done, n_cal, seed, i, j;
  adc_conv_ctrl uut (.clk, .rst, .s_axi_awaddr, .s_axi_awprot,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .hw_trig,
    .hw_trig_sel, .stat, .conv, .irq);
  conv_core_model core (.clk, .rst, .conv, .cmp, .lat, .stat);
  // Clock and event counters
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    if (conv.start === 1'b1) n_start++;
    if (conv.abort === 1'b1) n_abort++;
    if (stat.done === 1'b1) n_done++;
    if (stat.cal_done === 1'b1) n_cal++;
  end
  function automatic logic [31:0] exp_res(input logic [4:0] c);
    return {16'h0, c, 11'h2a5};
  endfunction
  task automatic chk(input logic [31:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic hang();
    failures++;
    $display("[FAIL] %0t wait ran out", $time);
    wrap_up();
  endtask
  // Bus cycles: hold each channel until its ready is sampled
  task automatic wr(input logic [31:0] a, v, input logic [1:0] e);
    int k;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (k = 0; k < 60; k++) begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) break;
    end
    s_axi_bready <= 1'b0;
    if (k == 60) hang();
    chk({30'h0, s_axi_bresp}, {30'h0, e});
  endtask
  task automatic rchk(input logic [31:0] a, v, input logic [1:0] e);
    int k;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (k = 0; k < 60; k++) begin
      @(posedge clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) break;
    end
    s_axi_rready <= 1'b0;
    if (k == 60) hang();
    chk(s_axi_rdata, v);
    chk({30'h0, s_axi_rresp}, {30'h0, e});
  endtask
  task automatic wait_ev(input int n, input bit cal);
    int k;
    for (k = 0; k < 900 && (cal ? n_cal : n_done) < n; k++) @(posedge clk);
    if (k == 900) hang();
    repeat (3) @(posedge clk);
  endtask
  task automatic trig(input logic s);
    @(posedge clk);
    hw_trig <= 1'b1;
    hw_trig_sel <= s;
    @(posedge clk);
    hw_trig <= 1'b0;
  endtask
  // Main sequence
  initial begin
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_awprot} = '0;
    {s_axi_arprot, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, hw_trig, hw_trig_sel, cmp} = '0;
    {failures, n_compared, n_start, n_abort, n_done, n_cal} = '0;
    s_axi_wstrb = 4'hf;
    lat = 8'h06;
    seed = 32'h1f00;
    rst = 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rchk(OFF_CTRL_A, CTRL_RST, RESP_OKAY);
    rchk(OFF_CTRL_B, CTRL_RST, RESP_OKAY);
    for (i = 0; i < NGEN; i++) rchk(GEN_OFF[i], GEN_RST[i], RESP_OKAY);
    rchk(OFF_RESULT_B, 32'h0, RESP_OKAY);
    rchk(32'h4003b030, 32'h0, RESP_SLVERR);
    wr(32'h4003b030, 32'h1, RESP_SLVERR);
    wr(OFF_CTRL_A, 32'hffffffff, RESP_OKAY);
    rchk(OFF_CTRL_A, CTRL_WMASK, RESP_OKAY);
    for (i = 0; i < 12; i++) begin
      j = $unsigned($random(seed)) % NGEN;
      if (j == IDX_SC2 || j == IDX_SC3) j = 0;
      d = $random(seed);
      wr(GEN_OFF[j], d, RESP_OKAY);
      rchk(GEN_OFF[j], d, RESP_OKAY);
    end
    chk(n_start, 0);
    // Software conversion on a random input with interrupt
    wr(OFF_INT_MASK, 32'h3, RESP_OKAY);
    ch = 5'($unsigned($random(seed)) % NUM_INPUTS);
    wr(OFF_CTRL_A, {24'h0, 3'h2, ch}, RESP_OKAY);
    wait_ev(1, 0);
    chk({31'h0, irq}, 32'h1);
    rchk(OFF_CTRL_A, {24'h0, 3'h6, ch}, RESP_OKAY);
    rchk(OFF_RESULT_A, exp_res(ch), RESP_OKAY);
    rchk(OFF_CTRL_A, {24'h0, 3'h2, ch}, RESP_OKAY);
    wr(OFF_INT_STATUS, 32'h1, RESP_OKAY);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    // Masked interrupt, flag cleared by a control write
    wr(OFF_INT_MASK, 32'h0, RESP_OKAY);
    wr(OFF_CTRL_A, 32'h43, RESP_OKAY);
    wait_ev(2, 0);
    chk({31'h0, irq}, 32'h0);
    rchk(OFF_INT_STATUS, 32'h1, RESP_OKAY);
    wr(OFF_CTRL_A, 32'h1f, RESP_OKAY);
    rchk(OFF_CTRL_A, 32'h1f, RESP_OKAY);
    chk(n_start, 2);
    wr(OFF_INT_STATUS, 32'h1, RESP_OKAY);
    wr(OFF_INT_MASK, 32'h3, RESP_OKAY);
    // Abort by rewriting the governing register
    lat = 8'h3c;
    wr(OFF_CTRL_A, 32'h04, RESP_OKAY);
    wr(OFF_CTRL_A, 32'h04, RESP_OKAY);
    repeat (80) @(posedge clk);
    chk(n_abort, 1);
    rchk(OFF_CTRL_A, 32'h84, RESP_OKAY);
    // Compare gate, false then true
    lat = 8'h06;
    wr(GEN_OFF[IDX_SC2], 32'h1 << COMPARE_FUNCTION_ENABLE_BIT, RESP_OKAY);
    for (i = 0; i < 2; i++) begin
      cmp = i[0];
      j = n_done;
      wr(OFF_CTRL_A, 32'h02, RESP_OKAY);
      wait_ev(j + 1, 0);
      rchk(OFF_CTRL_A, {24'h0, i[0], 7'h02}, RESP_OKAY);
    end
    wr(GEN_OFF[IDX_SC2], 32'h0, RESP_OKAY);
    // Hardware averaging of four conversions
    lat = 8'h14;
    wr(GEN_OFF[IDX_SC3], 32'h1 << HW_AVERAGE_ENABLE_BIT, RESP_OKAY);
    j = n_done;
    wr(OFF_CTRL_A, 32'h06, RESP_OKAY);
    wait_ev(j + 3, 0);
    rchk(OFF_CTRL_A, 32'h06, RESP_OKAY);
    wait_ev(j + 4, 0);
    rchk(OFF_CTRL_A, 32'h86, RESP_OKAY);
    rchk(OFF_RESULT_A, exp_res(5'h06), RESP_OKAY);
    // Calibration sets the flag of register A
    wr(GEN_OFF[IDX_SC3], 32'h1 << CAL_BIT, RESP_OKAY);
    wait_ev(1, 1);
    rchk(OFF_CTRL_A, 32'h86, RESP_OKAY);
    rchk(GEN_OFF[IDX_SC3], 32'h0, RESP_OKAY);
    // Hardware triggers alternating between the two registers
    wr(GEN_OFF[IDX_SC2], 32'h1 << TRG_BIT, RESP_OKAY);
    j = n_start;
    wr(OFF_CTRL_B, 32'h45, RESP_OKAY);
    chk(n_start, j);
    i = n_done;
    trig(1'b1);
    wait_ev(i + 1, 0);
    rchk(OFF_CTRL_B, 32'hc5, RESP_OKAY);
    chk({31'h0, irq}, 32'h1);
    rchk(OFF_RESULT_B, exp_res(5'h05), RESP_OKAY);
    trig(1'b0);
    wait_ev(i + 2, 0);
    rchk(OFF_RESULT_A, exp_res(5'h06), RESP_OKAY);
    lat = 8'h3c;
    j = n_abort;
    trig(1'b1);
    wr(OFF_CTRL_A, 32'h07, RESP_OKAY);
    chk(n_abort, j);
    wr(OFF_CTRL_B, 32'h45, RESP_OKAY);
    repeat (2) @(posedge clk);
    chk(n_abort, j + 1);
    wrap_up();
  end
endmodule
bind adc_conv_ctrl adc_conv_ctrl_chk chk_i (.clk, .rst, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_bvalid, .s_axi_bready, .conv);
